// ==== hdl/regulator_fault_supervisor.sv ====
// Purpose: Digital supervisor of a multiphase regulator: start-up, latch-off, output-good, crowbar, load offsets.
// Assumes: Analog comparators and ADC readings arrive as digital values; pins are synchronised here.
// Notes: Registers are reached through a decoded command port: one code, one byte, one cycle.
//
// Summary of operation
// - A latched shutdown clears when enable drops low or power cycles.
// - Latch-off enable bit 1 of both setup registers at zero disables latch-off.
// - Below 200 mV during start-up a secondary limit clamps the error level.
// - Output-good low when out of window, no-processor code, or enable low.
// - Voltage code change blanks output-good fault detection for 100 us.
// - Output-good waits for soft-start at code, then the mask interval.
// - Output-good upper and lower limits are software programmable registers.
// - Low-power input low drives the shed-phase driver disable low.
// - Above crowbar threshold, outside blanking, all PWM forced low until output falls under 300 mV.
// - Crowbar trip threshold equals the programmed output-good upper limit.
// - Start-up begins only with lockout released and enable high; else disabled.
// - While disabled PWM low, output-good and both driver disables low.
// - Current compared with third, second, then first threshold, selecting four states.
// - Each load state offset is programmable, magnitude clamped to 200 mV.
// - All four load state offset registers reset to zero.
// - Latch-off delay lasts four base delay intervals of a persisting fault.
// - Latch-off delay counts only after the turn-on mask interval completes.
// - Three-bit field selects base delay in 0.5 ms steps, 0.5 to 4 ms.
// - Each further voltage code change restarts the blanking timer.
module regulator_fault_supervisor #(
  parameter int STEP_CYCLES = supervisor_pkg::DELAY_STEP_CYCLES,
  parameter int BLANK_LEN = supervisor_pkg::BLANK_CYCLES,
  parameter int TIMER_WIDTH = 22
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_in,
  input wire logic supply_lockout_released,
  input wire logic low_power_state_input_n,
  input wire logic overcurrent_limit_hit,
  input wire logic [7:0] voltage_code,
  input wire logic soft_start_at_code,
  input wire logic [10:0] output_sense_reference_mv,
  input wire logic [7:0] total_output_current,
  input wire logic cmd_write,
  input wire logic cmd_read,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_wdata,
  output logic [7:0] cmd_rdata,
  output logic cmd_ack,
  input wire logic output_good_in,
  output logic output_good_out,
  output logic output_good_oe,
  output logic pwm_force_low,
  output logic shed_phase_driver_disable_n,
  output logic main_phase_driver_disable_n,
  output logic secondary_limit_active,
  output logic latched_off,
  output logic [1:0] load_state,
  output logic [7:0] applied_offset
);

  supervisor_pkg::pin_in_t pin_raw;
  supervisor_pkg::pin_in_t pin_meta_ff;
  supervisor_pkg::pin_in_t pin_sync_ff;
  supervisor_pkg::seq_state_t state_ff;
  supervisor_pkg::seq_state_t nxt_state;
  logic [7:0] setup_a_ff;
  logic [7:0] setup_b_ff;
  logic [7:0] delay_ff;
  logic [7:0] good_high_ff;
  logic [7:0] good_low_ff;
  logic [7:0] thresh_one_ff;
  logic [7:0] thresh_two_ff;
  logic [7:0] thresh_three_ff;
  logic [3:0][7:0] offset_ff;
  logic [7:0] code_prev_ff;
  logic crowbar_ff;
  logic good_ff;
  logic latch_armed_ff;
  logic [7:0] nxt_rdata;
  logic enabled;
  logic latchoff_enable;
  logic no_processor;
  logic code_changed;
  logic [10:0] high_mv;
  logic [10:0] low_mv;
  logic in_window;
  logic [TIMER_WIDTH-1:0] base_cycles;
  logic [TIMER_WIDTH-1:0] seq_load;
  logic seq_start;
  logic seq_stop;
  logic seq_busy;
  logic seq_done;
  logic blank_busy;
  logic blank_done;
  logic [1:0] sel_state;
  logic [7:0] sel_offset;

  generate
    if (STEP_CYCLES < 1 || BLANK_LEN < 1) begin : g_bad_times
      $error("regulator_fault_supervisor timing parameters must be positive");
    end
    if (64'(STEP_CYCLES) * 64'(supervisor_pkg::LATCH_MULT * 8) >= (64'd1 << TIMER_WIDTH)) begin : g_bad_width
      $error("regulator_fault_supervisor TIMER_WIDTH too small for the latch-off delay");
    end
    if (64'(BLANK_LEN) >= (64'd1 << TIMER_WIDTH)) begin : g_bad_blank
      $error("regulator_fault_supervisor TIMER_WIDTH too small for the blanking window");
    end
  endgenerate

  assign pin_raw = '{enable: enable_in, supply_ok: supply_lockout_released,
                     low_power_n: low_power_state_input_n, limit_hit: overcurrent_limit_hit,
                     voltage_code: voltage_code};

  // Two-stage synchroniser for every pin input; the first stage feeds only the second.
  always_ff @(posedge clk) begin
    if (reset) begin
      pin_meta_ff <= '0;
      pin_sync_ff <= '0;
    end else begin
      pin_meta_ff <= pin_raw;
      pin_sync_ff <= pin_meta_ff;
    end
  end

  assign enabled = pin_sync_ff.enable && pin_sync_ff.supply_ok;
  // latch-off disable needs both bits clear
  assign latchoff_enable = setup_a_ff[supervisor_pkg::LATCHOFF_EN_BIT] ||
                           setup_b_ff[supervisor_pkg::LATCHOFF_EN_BIT];
  assign no_processor = (pin_sync_ff.voltage_code == supervisor_pkg::CODE_OFF_A) ||
                        (pin_sync_ff.voltage_code == supervisor_pkg::CODE_OFF_B);
  assign code_changed = (pin_sync_ff.voltage_code != code_prev_ff);

  assign high_mv = {good_high_ff, 3'b000};
  assign low_mv = {good_low_ff, 3'b000};
  assign in_window = (output_sense_reference_mv <= high_mv) && (output_sense_reference_mv >= low_mv);

  assign base_cycles = TIMER_WIDTH'((32'(delay_ff[supervisor_pkg::DELAY_CODE_MSB:0]) + 32'd1) * STEP_CYCLES);

  // Register write port; software writes steer the sequence timer, window and offsets.
  always_ff @(posedge clk) begin
    if (reset) begin
      setup_a_ff <= supervisor_pkg::SETUP_RESET;
      setup_b_ff <= supervisor_pkg::SETUP_RESET;
      delay_ff <= supervisor_pkg::DELAY_RESET;
      good_high_ff <= supervisor_pkg::GOOD_HIGH_RESET;
      good_low_ff <= supervisor_pkg::GOOD_LOW_RESET;
      thresh_one_ff <= supervisor_pkg::THRESH_ONE_RESET;
      thresh_two_ff <= supervisor_pkg::THRESH_TWO_RESET;
      thresh_three_ff <= supervisor_pkg::THRESH_THREE_RESET;
      offset_ff <= {4{supervisor_pkg::OFFSET_RESET}};
    end else if (cmd_write) begin
      case (cmd_code)
        supervisor_pkg::REG_SETUP_A: setup_a_ff <= cmd_wdata;
        supervisor_pkg::REG_SETUP_B: setup_b_ff <= cmd_wdata;
        supervisor_pkg::REG_DELAY: delay_ff <= {5'h00, cmd_wdata[supervisor_pkg::DELAY_CODE_MSB:0]};
        supervisor_pkg::REG_GOOD_HIGH: good_high_ff <= cmd_wdata;
        supervisor_pkg::REG_GOOD_LOW: good_low_ff <= cmd_wdata;
        supervisor_pkg::REG_THRESH_ONE: thresh_one_ff <= cmd_wdata;
        supervisor_pkg::REG_THRESH_TWO: thresh_two_ff <= cmd_wdata;
        supervisor_pkg::REG_THRESH_THREE: thresh_three_ff <= cmd_wdata;
        supervisor_pkg::REG_OFFSET_ONE: offset_ff[0] <= cmd_wdata;
        supervisor_pkg::REG_OFFSET_TWO: offset_ff[1] <= cmd_wdata;
        supervisor_pkg::REG_OFFSET_THREE: offset_ff[2] <= cmd_wdata;
        supervisor_pkg::REG_OFFSET_FOUR: offset_ff[3] <= cmd_wdata;
        default: begin
        end
      endcase
    end
  end

  // Read mux; unknown codes answer zero rather than stale data.
  always_comb begin
    case (cmd_code)
      supervisor_pkg::REG_SETUP_A: nxt_rdata = setup_a_ff;
      supervisor_pkg::REG_SETUP_B: nxt_rdata = setup_b_ff;
      supervisor_pkg::REG_DELAY: nxt_rdata = delay_ff;
      supervisor_pkg::REG_GOOD_HIGH: nxt_rdata = good_high_ff;
      supervisor_pkg::REG_GOOD_LOW: nxt_rdata = good_low_ff;
      supervisor_pkg::REG_THRESH_ONE: nxt_rdata = thresh_one_ff;
      supervisor_pkg::REG_THRESH_TWO: nxt_rdata = thresh_two_ff;
      supervisor_pkg::REG_THRESH_THREE: nxt_rdata = thresh_three_ff;
      supervisor_pkg::REG_OFFSET_ONE: nxt_rdata = offset_ff[0];
      supervisor_pkg::REG_OFFSET_TWO: nxt_rdata = offset_ff[1];
      supervisor_pkg::REG_OFFSET_THREE: nxt_rdata = offset_ff[2];
      supervisor_pkg::REG_OFFSET_FOUR: nxt_rdata = offset_ff[3];
      supervisor_pkg::REG_STATUS: nxt_rdata = {state_ff == supervisor_pkg::ST_LATCHED, crowbar_ff, good_ff,
                                               blank_busy, state_ff == supervisor_pkg::ST_RUN, enabled,
                                               load_state};
      default: nxt_rdata = 8'h00;
    endcase
  end

  // Read data and acknowledge, one cycle after the request.
  always_ff @(posedge clk) begin
    if (reset) begin
      cmd_rdata <= 8'h00;
      cmd_ack <= 1'b0;
    end else begin
      cmd_ack <= cmd_write || cmd_read;
      if (cmd_read) begin
        cmd_rdata <= nxt_rdata;
      end
    end
  end

  // Start-up sequence; dropping enable or lockout always returns to off.
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      supervisor_pkg::ST_OFF: begin
        if (enabled) begin
          nxt_state = supervisor_pkg::ST_WAIT_SS;
        end
      end
      supervisor_pkg::ST_WAIT_SS: begin
        if (soft_start_at_code) begin
          nxt_state = supervisor_pkg::ST_MASK;
        end
      end
      supervisor_pkg::ST_MASK: begin
        if (seq_done) begin
          nxt_state = supervisor_pkg::ST_RUN;
        end
      end
      supervisor_pkg::ST_RUN: begin
        if (seq_done && latch_armed_ff && latchoff_enable) begin
          nxt_state = supervisor_pkg::ST_LATCHED;
        end
      end
      supervisor_pkg::ST_LATCHED: begin
        nxt_state = supervisor_pkg::ST_LATCHED;
      end
      default: nxt_state = supervisor_pkg::ST_OFF;
    endcase
    if (!enabled) begin
      nxt_state = supervisor_pkg::ST_OFF;
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      state_ff <= supervisor_pkg::ST_OFF;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // One shared timer serves the mask interval and then the latch-off delay.
  // latch-off only after mask
  assign seq_start = ((state_ff == supervisor_pkg::ST_WAIT_SS) && soft_start_at_code) ||
                     ((state_ff == supervisor_pkg::ST_RUN) && pin_sync_ff.limit_hit && !latch_armed_ff);
  assign seq_stop = !enabled || ((state_ff == supervisor_pkg::ST_RUN) && !pin_sync_ff.limit_hit);
  assign seq_load = (state_ff == supervisor_pkg::ST_RUN) ?
                    TIMER_WIDTH'(32'(base_cycles) * supervisor_pkg::LATCH_MULT) : base_cycles;

  // The latch-off delay is armed while the fault persists; a cleared fault lets the loop recover.
  always_ff @(posedge clk) begin
    if (reset) begin
      latch_armed_ff <= 1'b0;
    end else if (seq_stop || state_ff != supervisor_pkg::ST_RUN) begin
      latch_armed_ff <= 1'b0;
    end else if (seq_start) begin
      latch_armed_ff <= 1'b1;
    end else if (seq_done) begin
      // With latch-off disabled the controller stays in current limit and re-arms later.
      latch_armed_ff <= 1'b0;
    end
  end

  delay_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_seq_timer (
    .clk(clk),
    .reset(reset),
    .start(seq_start),
    .stop(seq_stop),
    .load_value(seq_load),
    .busy(seq_busy),
    .done(seq_done)
  );

  // Previous synchronised code, for change detection.
  always_ff @(posedge clk) begin
    if (reset) begin
      code_prev_ff <= 8'h00;
    end else begin
      code_prev_ff <= pin_sync_ff.voltage_code;
    end
  end

  delay_timer #(
    .WIDTH(TIMER_WIDTH)
  ) u_blank_timer (
    .clk(clk),
    .reset(reset),
    .start(code_changed),
    .stop(1'b0),
    .load_value(TIMER_WIDTH'(BLANK_LEN)),
    .busy(blank_busy),
    .done(blank_done)
  );

  // Crowbar trips above the upper limit outside blanking and holds until the output is nearly discharged.
  always_ff @(posedge clk) begin
    if (reset) begin
      crowbar_ff <= 1'b0;
    end else if (!enabled) begin
      crowbar_ff <= 1'b0;
    end else if (output_sense_reference_mv > high_mv && !blank_busy) begin
      crowbar_ff <= 1'b1;
    end else if (output_sense_reference_mv < supervisor_pkg::CROWBAR_RELEASE_MV) begin
      crowbar_ff <= 1'b0;
    end
  end

  // Output-good: during blanking the window fault is ignored so a moving output reads good.
  always_ff @(posedge clk) begin
    if (reset) begin
      good_ff <= 1'b0;
    end else begin
      good_ff <= enabled && (state_ff == supervisor_pkg::ST_RUN) && !no_processor && !crowbar_ff &&
                 (in_window || blank_busy);
    end
  end

  load_state_select u_load_state (
    .total_output_current(total_output_current),
    .load_threshold_one(thresh_one_ff),
    .load_threshold_two(thresh_two_ff),
    .load_threshold_three(thresh_three_ff),
    .offsets(offset_ff),
    .load_state(sel_state),
    .applied_offset(sel_offset)
  );

  // Registered outputs toward the drivers and the loop.
  always_ff @(posedge clk) begin
    if (reset) begin
      output_good_out <= 1'b0;
      output_good_oe <= 1'b1;
      pwm_force_low <= 1'b1;
      shed_phase_driver_disable_n <= 1'b0;
      main_phase_driver_disable_n <= 1'b0;
      secondary_limit_active <= 1'b0;
      latched_off <= 1'b0;
      load_state <= 2'h0;
      applied_offset <= 8'h00;
    end else begin
      output_good_out <= 1'b0;
      output_good_oe <= !nxt_good_view(good_ff);
      pwm_force_low <= !enabled || crowbar_ff || state_ff == supervisor_pkg::ST_LATCHED ||
                       state_ff == supervisor_pkg::ST_OFF;
      shed_phase_driver_disable_n <= enabled && state_ff != supervisor_pkg::ST_OFF &&
                                     state_ff != supervisor_pkg::ST_LATCHED && pin_sync_ff.low_power_n;
      main_phase_driver_disable_n <= enabled && state_ff != supervisor_pkg::ST_OFF &&
                                     state_ff != supervisor_pkg::ST_LATCHED;
      secondary_limit_active <= enabled && (state_ff == supervisor_pkg::ST_WAIT_SS ||
                                state_ff == supervisor_pkg::ST_MASK) &&
                                output_sense_reference_mv < supervisor_pkg::SECONDARY_LIMIT_MV;
      latched_off <= state_ff == supervisor_pkg::ST_LATCHED;
      load_state <= sel_state;
      applied_offset <= sel_offset;
    end
  end

  // Open-drain view: the pin is released only for a good output.
  function automatic logic nxt_good_view(input logic good);
    return good;
  endfunction

endmodule

// ==== hdl/supervisor_pkg.sv ====
// Purpose: Shared constants, types and register map of the regulator fault supervisor.
// Assumes: A 200 MHz core clock; register codes are eight-bit command codes.
// Notes: Limits are held in 8 mV units, currents in whole amps, offsets in sign-magnitude steps.
package supervisor_pkg;

  // Clock period in nanoseconds.
  localparam int CLK_PERIOD_NS = 5;

  // One step of the base delay interval, and the output-good blanking window.
  localparam int DELAY_STEP_NS = 500000;
  localparam int DELAY_STEP_CYCLES = (DELAY_STEP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BLANK_TIME_NS = 100000;
  localparam int BLANK_CYCLES = (BLANK_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Latch-off delay as a multiple of the base delay interval.
  localparam int LATCH_MULT = 4;

  // Analog thresholds in millivolts.
  localparam logic [10:0] SECONDARY_LIMIT_MV = 11'h0C8;
  localparam logic [10:0] CROWBAR_RELEASE_MV = 11'h12C;

  // Offset step and largest applied magnitude.
  localparam int OFFSET_STEP_UV = 6250;
  localparam int OFFSET_MAX_UV = 200000;
  localparam logic [6:0] OFFSET_MAX_CODE = 7'(OFFSET_MAX_UV / OFFSET_STEP_UV);

  // Command codes of the registers.
  localparam logic [7:0] REG_SETUP_A = 8'hD2;
  localparam logic [7:0] REG_SETUP_B = 8'hD3;
  localparam logic [7:0] REG_DELAY = 8'hD4;
  localparam logic [7:0] REG_GOOD_HIGH = 8'hE3;
  localparam logic [7:0] REG_GOOD_LOW = 8'hE4;
  localparam logic [7:0] REG_THRESH_ONE = 8'hE5;
  localparam logic [7:0] REG_THRESH_TWO = 8'hE6;
  localparam logic [7:0] REG_THRESH_THREE = 8'hE7;
  localparam logic [7:0] REG_OFFSET_ONE = 8'hE8;
  localparam logic [7:0] REG_OFFSET_TWO = 8'hE9;
  localparam logic [7:0] REG_OFFSET_THREE = 8'hEA;
  localparam logic [7:0] REG_OFFSET_FOUR = 8'hEB;
  localparam logic [7:0] REG_STATUS = 8'hEC;

  // Field positions.
  localparam int LATCHOFF_EN_BIT = 1;
  localparam int DELAY_CODE_MSB = 2;
  localparam int OFFSET_SIGN_BIT = 7;

  // Reset values.
  localparam logic [7:0] SETUP_RESET = 8'h02;
  localparam logic [7:0] DELAY_RESET = 8'h03;
  localparam logic [7:0] GOOD_HIGH_RESET = 8'hC8;
  localparam logic [7:0] GOOD_LOW_RESET = 8'h2F;
  localparam logic [7:0] THRESH_ONE_RESET = 8'h40;
  localparam logic [7:0] THRESH_TWO_RESET = 8'h60;
  localparam logic [7:0] THRESH_THREE_RESET = 8'h80;
  localparam logic [7:0] OFFSET_RESET = 8'h00;

  // Voltage codes that mean no processor is fitted.
  localparam logic [7:0] CODE_OFF_A = 8'h00;
  localparam logic [7:0] CODE_OFF_B = 8'h01;

  // Start-up sequence states.
  typedef enum logic [2:0] {
    ST_OFF,
    ST_WAIT_SS,
    ST_MASK,
    ST_RUN,
    ST_LATCHED
  } seq_state_t;

  // Inputs that arrive from pins and must be synchronised.
  typedef struct packed {
    logic enable;
    logic supply_ok;
    logic low_power_n;
    logic limit_hit;
    logic [7:0] voltage_code;
  } pin_in_t;

endpackage

// ==== hdl/delay_timer.sv ====
// Purpose: Down-counter that times one interval and pulses done at its end.
// Assumes: start and stop come from logic on the same clock.
// Notes: stop wins over start; a start while busy restarts the interval.
module delay_timer #(
  parameter int WIDTH = 22
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic start,
  input wire logic stop,
  input wire logic [WIDTH-1:0] load_value,
  output logic busy,
  output logic done
);

  logic [WIDTH-1:0] count_ff;

  generate
    if (WIDTH < 2) begin : g_bad_width
      $error("delay_timer WIDTH must be at least 2");
    end
  endgenerate

  // Count down from the loaded value; zero means idle.
  always_ff @(posedge clk) begin
    if (reset || stop) begin
      count_ff <= '0;
    end else if (start) begin
      count_ff <= load_value;
    end else if (count_ff != '0) begin
      count_ff <= count_ff - 1'b1;
    end
  end

  assign busy = (count_ff != '0);
  // The last tick is flagged only when nothing reloads or aborts it.
  assign done = (count_ff == WIDTH'(1)) && !start && !stop;

endmodule

// ==== hdl/load_state_select.sv ====
// Purpose: Picks the load state from the total current and yields that state's clamped offset.
// Assumes: Current and thresholds share one unit; thresholds are ordered by software.
// Notes: Pure combinational; the top registers the results.
module load_state_select (
  input wire logic [7:0] total_output_current,
  input wire logic [7:0] load_threshold_one,
  input wire logic [7:0] load_threshold_two,
  input wire logic [7:0] load_threshold_three,
  input wire logic [3:0][7:0] offsets,
  output logic [1:0] load_state,
  output logic [7:0] applied_offset
);

  logic [3:0][7:0] clamped;

  // Sign-magnitude offset limited to the largest allowed magnitude.
  function automatic logic [7:0] clamp_offset(input logic [7:0] raw);
    logic [6:0] mag;
    mag = raw[6:0];
    if (mag > supervisor_pkg::OFFSET_MAX_CODE) begin
      mag = supervisor_pkg::OFFSET_MAX_CODE;
    end
    return {raw[supervisor_pkg::OFFSET_SIGN_BIT], mag};
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < 4; gi++) begin : g_clamp
      assign clamped[gi] = clamp_offset(offsets[gi]);
    end
  endgenerate

  // Highest threshold is tested first; equality counts as not exceeding.
  always_comb begin
    if (total_output_current > load_threshold_three) begin
      load_state = 2'h3;
    end else if (total_output_current > load_threshold_two) begin
      load_state = 2'h2;
    end else if (total_output_current > load_threshold_one) begin
      load_state = 2'h1;
    end else begin
      load_state = 2'h0;
    end
    applied_offset = clamped[load_state];
  end

endmodule

// ==== testbench/supervisor_sva.sv ====
// Purpose: Port assertions for the regulator fault supervisor.
// Assumes: Pins pass two sync stages, then one register, or two for output-good and latched_off.
// Notes: The latch-off bound assumes the smallest delay code.
module supervisor_sva #(parameter int STEP_CYCLES = 4) (
  input wire logic clk,
  input wire logic reset,
  input wire logic enable_in,
  input wire logic supply_lockout_released,
  input wire logic low_power_state_input_n,
  input wire logic overcurrent_limit_hit,
  input wire logic [7:0] voltage_code,
  input wire logic [10:0] output_sense_reference_mv,
  input wire logic output_good_oe,
  input wire logic pwm_force_low,
  input wire logic shed_phase_driver_disable_n,
  input wire logic main_phase_driver_disable_n,
  input wire logic secondary_limit_active,
  input wire logic latched_off
);
  int hit_run_ff;
  default clocking @(posedge clk); endclocking
  default disable iff (reset);
  // Length of the current limit run; a shutdown before four base steps is early.
  always_ff @(posedge clk) begin
    hit_run_ff <= (reset || !overcurrent_limit_hit) ? 0 : hit_run_ff + 1;
  end
  a_disabled_safe: assert property (!enable_in [*5] |-> output_good_oe && pwm_force_low &&
    !shed_phase_driver_disable_n && !main_phase_driver_disable_n) else $error("outputs live while disabled");
  a_lockout_holds: assert property (!supply_lockout_released [*5] |-> output_good_oe &&
    !main_phase_driver_disable_n) else $error("running under lockout");
  a_shed_low_power: assert property (!low_power_state_input_n [*4] |-> !shed_phase_driver_disable_n)
    else $error("shed phases still enabled");
  a_off_code_bad: assert property ((voltage_code inside {8'h00, 8'h01}) [*5] |-> output_good_oe)
    else $error("good with no processor");
  a_latch_delay: assert property ($rose(latched_off) |-> hit_run_ff >= 4 * STEP_CYCLES)
    else $error("latch-off too early");
  a_latch_safe: assert property (latched_off [*2] |-> pwm_force_low && !main_phase_driver_disable_n)
    else $error("latched but switching");
  a_latch_clears: assert property (!enable_in [*5] |-> !latched_off) else $error("latch kept");
  a_secondary_low: assert property (secondary_limit_active |->
    $past(output_sense_reference_mv) < supervisor_pkg::SECONDARY_LIMIT_MV) else $error("clamp above limit");
  c_latched: cover property ($rose(latched_off));
  c_good: cover property ($fell(output_good_oe));
  c_clamp: cover property (secondary_limit_active);
endmodule
bind regulator_fault_supervisor supervisor_sva #(.STEP_CYCLES(STEP_CYCLES)) sva_i (.clk, .reset, .enable_in,
  .supply_lockout_released, .low_power_state_input_n, .overcurrent_limit_hit, .voltage_code,
  .output_sense_reference_mv, .output_good_oe, .pwm_force_low, .shed_phase_driver_disable_n,
  .main_phase_driver_disable_n, .secondary_limit_active, .latched_off);

// ==== testbench/rail_model.sv ====
// Purpose: Behavioural phase drivers and output rail facing the supervisor.
// Assumes: The rail slews 100 mV a cycle toward its target.
// Notes: Forcing PWM low discharges the rail, as the low-side switches would.
module rail_model (
  input wire logic clk,
  input wire logic pwm_force_low,
  input wire logic [10:0] target_mv,
  output logic [10:0] rail_mv,
  output logic at_code
);
  initial rail_mv = 11'h000;
  always @(posedge clk) begin
    if (pwm_force_low) rail_mv <= (rail_mv > 11'h064) ? rail_mv - 11'h064 : 11'h000;
    else if (rail_mv + 11'h064 <= target_mv) rail_mv <= rail_mv + 11'h064;
    else if (rail_mv >= target_mv + 11'h064) rail_mv <= rail_mv - 11'h064;
    else rail_mv <= target_mv;
  end
  assign at_code = (rail_mv == target_mv);
endmodule

// ==== testbench/testbench.sv ====
// Purpose: Self-checking bench for the regulator fault supervisor.
// Assumes: Short timer parameters stand in for the millisecond delays.
// Notes: Inputs change on the falling edge so edge races cannot arise.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed {logic [7:0] cur; logic [7:0] st; logic [7:0] off;} row_t;
  logic clk = 0, reset = 1, en = 0, sup = 0, lp_n = 1, hit = 0, wr = 0, rd = 0, at_code, ack, oe, pwm, shed_n, main_n;
  logic sec, latch, ogo;
  logic [7:0] code = 8'h00, cmd = 8'h00, wd = 8'h00, cur = 8'h00, rdat, offs;
  logic [10:0] tgt = 11'h3E8, mv;
  logic [1:0] st;
  int fail_count = 0, n_compared = 0, cyc = 0;
  logic [7:0] ow[4] = '{8'h05, 8'h85, 8'h7F, 8'hFF};
  row_t rows[7] = '{'{8'h30, 8'h00, 8'h05}, '{8'h40, 8'h00, 8'h05}, '{8'h41, 8'h01, 8'h85}, '{8'h60, 8'h01, 8'h85},
    '{8'h61, 8'h02, 8'h20}, '{8'h80, 8'h02, 8'h20}, '{8'h81, 8'h03, 8'hA0}};
  rail_model rail (.clk(clk), .pwm_force_low(pwm), .target_mv(tgt), .rail_mv(mv), .at_code(at_code));
  regulator_fault_supervisor #(.STEP_CYCLES(4), .BLANK_LEN(40)) dut (.clk(clk), .reset(reset), .enable_in(en),
    .supply_lockout_released(sup), .low_power_state_input_n(lp_n), .overcurrent_limit_hit(hit), .voltage_code(code),
    .soft_start_at_code(at_code), .output_sense_reference_mv(mv), .total_output_current(cur), .cmd_write(wr),
    .cmd_read(rd), .cmd_code(cmd), .cmd_wdata(wd), .cmd_rdata(rdat), .cmd_ack(ack), .output_good_in(!oe),
    .output_good_out(ogo), .output_good_oe(oe), .pwm_force_low(pwm), .shed_phase_driver_disable_n(shed_n),
    .main_phase_driver_disable_n(main_n), .secondary_limit_active(sec), .latched_off(latch), .load_state(st),
    .applied_offset(offs));
  // Clock, and a ceiling on the run in case a wait never ends.
  always #2.5 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      fail_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // One command, then an idle edge so strobes never toggle twice at once; read data stands until the next read.
  task automatic cmd_rw(input logic w, input logic [7:0] c, input logic [7:0] d);
    wr = w;
    rd = !w;
    cmd = c;
    wd = d;
    tick(1);
    check(8'(ack), 8'h01);
    wr = 0;
    rd = 0;
    tick(1);
  endtask
  function automatic logic pick(input int k);
    return k == 0 ? oe : k == 1 ? pwm : k == 2 ? latch : at_code;
  endfunction
  task automatic wait_on(input int k, input logic want);
    for (int i = 0; i < 400 && pick(k) !== want; i++) tick(1);
  endtask
  initial begin
    tick(16);
    reset = 0;
    tick(2);
    for (int i = 0; i < 4; i++) begin
      cmd_rw(0, 8'hE8 + 8'(i), 8'h00);
      check(rdat, 8'h00);
      cmd_rw(1, 8'hE8 + 8'(i), ow[i]);
    end
    cmd_rw(0, 8'hD4, 8'h00);
    check(rdat, 8'h03);
    cmd_rw(1, 8'hD4, 8'hFF);
    cmd_rw(0, 8'hD4, 8'h00);
    check(rdat, 8'h07);
    cmd_rw(1, 8'hD4, 8'h03);
    cmd_rw(0, 8'hD2, 8'h00);
    check(rdat, 8'h02);
    cmd_rw(0, 8'h55, 8'h00);
    check(rdat, 8'h00);
    foreach (rows[i]) begin
      cur = rows[i].cur;
      tick(3);
      check(8'(st), rows[i].st);
      check(offs, rows[i].off);
    end
    code = 8'h40;
    en = 1;
    sup = 1;
    wait_on(3, 1);
    check(8'(oe), 8'h01);
    wait_on(0, 0);
    check(8'(oe), 8'h00);
    lp_n = 0;
    tick(5);
    check(8'(shed_n), 8'h00);
    lp_n = 1;
    code = 8'h41;
    tick(3);
    tgt = 11'h064;
    tick(17);
    check(8'(oe), 8'h00);
    code = 8'h42;
    tick(30);
    check(8'(oe), 8'h00);
    tick(25);
    check(8'(oe), 8'h01);
    tgt = 11'h3E8;
    wait_on(0, 0);
    cmd_rw(1, 8'hE3, 8'h64);
    wait_on(1, 1);
    check(8'(pwm), 8'h01);
    cmd_rw(1, 8'hE3, 8'hC8);
    wait_on(1, 0);
    check(8'(mv < 11'h12C), 8'h01);
    wait_on(0, 0);
    code = 8'h01;
    tick(5);
    check(8'(oe), 8'h01);
    code = 8'h40;
    wait_on(0, 0);
    hit = 1;
    wait_on(2, 1);
    check(8'(main_n), 8'h00);
    hit = 0;
    en = 0;
    tick(5);
    check(8'(latch), 8'h00);
    cmd_rw(1, 8'hD2, 8'h00);
    cmd_rw(1, 8'hD3, 8'h00);
    en = 1;
    wait_on(0, 0);
    hit = 1;
    tick(300);
    check(8'(latch), 8'h00);
    hit = 0;
    sup = 0;
    tick(5);
    check({5'h00, ogo, pwm, main_n}, 8'h02);
    test_done();
  end
endmodule
